// file: src/slb_pkg.sv
/*
 * shared constants, types and small decoders of the store-through line buffer.
 * assumes: one core clock, byte 0 of a storage word sits in bits 31:24.
 */
package slb_pkg;

	// ------------------------------------------------------------
	// storage interface geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 25;
	localparam int DATA_W = 32;
	localparam int BUS_W = 36;
	localparam int SEL_W = 4;
	localparam int CODE_W = 3;
	localparam int LINE_BYTES = 16;
	localparam int OFS_W = 4;
	localparam int LINE_WORDS = 4;
	localparam int WORD_W = 2;
	localparam int SETS = 2;
	localparam int SMALL_ROWS = 512;
	localparam int LARGE_ROWS = 2048;
	localparam logic [1:0] LAST_WORD = 2'h3;
	localparam logic [3:0] SEL_ALL = 4'hf;

	// ------------------------------------------------------------
	// requester codes and mode lines
	// ------------------------------------------------------------
	localparam logic [2:0] CODE_IFETCH = 3'h0;
	localparam logic [2:0] CODE_PROG_READ = 3'h1;
	localparam logic [2:0] CODE_MAINT = 3'h2;
	localparam logic [2:0] CODE_TRACE = 3'h3;
	localparam logic [2:0] CODE_PREFETCH = 3'h4;
	localparam logic [2:0] CODE_CHANNEL = 3'h5;
	localparam int MODE_W = 8;
	localparam int MODE_ENABLE_BIT = 0;
	localparam logic [7:0] MODE_RESET = 8'h01;

	typedef enum logic [1:0] {SLB_SZ_BYTE, SLB_SZ_HALF, SLB_SZ_WORD} slb_size_t;

	// byte lanes touched by a core access; bit b is storage byte b
	function automatic logic [3:0] slb_byte_sel(input slb_size_t sz, input logic [1:0] lo);
		logic [3:0] sel;
		sel = 4'h0;
		case (sz)
			SLB_SZ_BYTE: sel[lo] = 1'b1;
			SLB_SZ_HALF: sel = lo[1] ? 4'hc : 4'h3;
			default: sel = SEL_ALL;
		endcase
		return sel;
	endfunction : slb_byte_sel

	// odd parity per byte, carried in bits 35:32
	function automatic logic [35:0] slb_with_par(input logic [31:0] w);
		logic [3:0] p;
		p = 4'h0;
		for (int b = 0; b < 4; b++) begin
			p[b] = ~^w[31 - 8 * b -: 8];
		end
		return {p, w};
	endfunction : slb_with_par

endpackage : slb_pkg

// file: src/slb_dir_if.sv
/*
 * carrier between the buffer controller and its two-set directory.
 * assumes: the directory answers lookups combinationally on idx and tag.
 */
`timescale 1ns/1ns
interface slb_dir_if #(parameter int IDX_W = 9, parameter int TAG_W = 12);
	logic [IDX_W-1:0] idx;
	logic [TAG_W-1:0] tag;
	logic hit;
	logic hit_set;
	logic victim;
	logic touch;
	logic fill;
	logic inval;
	logic set;

	modport ctl (output idx, tag, touch, fill, inval, set, input hit, hit_set, victim);
	modport dir (input idx, tag, touch, fill, inval, set, output hit, hit_set, victim);
endinterface : slb_dir_if

// file: src/slb_directory.sv
/*
 * two-set associative directory: tags, valid bits and one lru bit per row.
 * assumes: at most one of touch, fill, inval is high in a cycle.
 */
`timescale 1ns/1ns
module slb_directory #(
	parameter int ROWS = slb_pkg::SMALL_ROWS,
	parameter int IDX_W = 9,
	parameter int TAG_W = 12
) (
	input wire logic mclk,
	input wire logic reset,
	slb_dir_if.dir d
);

	logic [slb_pkg::SETS-1:0] hit_vec;
	// lru_reg names the set to replace next
	logic [ROWS-1:0] lru_reg;

	// ------------------------------------------------------------
	// per-set tag store and valid bits
	// ------------------------------------------------------------
	for (genvar s = 0; s < slb_pkg::SETS; s++) begin : g_set
		logic [TAG_W-1:0] tag_mem [ROWS];
		logic [ROWS-1:0] valid_reg;

		assign hit_vec[s] = valid_reg[d.idx] && (tag_mem[d.idx] == d.tag);

		always_ff @(posedge mclk) begin
			if (reset) begin
				valid_reg <= '0;
			end else if (d.fill && d.set == 1'(s)) begin
				valid_reg[d.idx] <= 1'b1;
			end else if (d.inval && hit_vec[s]) begin
				valid_reg[d.idx] <= 1'b0;
			end
		end

		always_ff @(posedge mclk) begin
			if (d.fill && d.set == 1'(s)) begin
				tag_mem[d.idx] <= d.tag;
			end
		end
	end

	assign d.hit = |hit_vec;
	assign d.hit_set = hit_vec[1];
	assign d.victim = lru_reg[d.idx];

	// ------------------------------------------------------------
	// lru: a used set makes the other one the victim
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			lru_reg <= '0;
		end else if (d.touch || d.fill) begin
			lru_reg[d.idx] <= ~d.set;
		end else if (d.inval && d.hit) begin
			lru_reg[d.idx] <= d.hit_set;
		end
	end

endmodule : slb_directory

// file: src/slb_line_buffer.sv
/*
 * store-through line buffer between the central core and the storage
 * controller: hit service, line fill, write-through and line invalidation.
 * assumes: core and storage controller run on mclk; core_req is held
 * until core_ack; the controller answers a grant and then data_valid words.
 */
`timescale 1ns/1ns
module slb_line_buffer #(
	parameter int ROWS = slb_pkg::SMALL_ROWS
) (
	input wire logic mclk,
	input wire logic reset,
	// core side
	input wire logic core_req,
	input wire logic core_we,
	input wire slb_pkg::slb_size_t core_size,
	input wire logic [slb_pkg::ADDR_W-1:0] core_addr,
	input wire logic [slb_pkg::CODE_W-1:0] core_code,
	input wire logic [slb_pkg::DATA_W-1:0] core_wdata,
	output logic core_ack,
	output logic [slb_pkg::DATA_W-1:0] core_rdata,
	output logic buffer_miss,
	input wire logic mode_load,
	input wire logic [slb_pkg::MODE_W-1:0] mode_data,
	output logic [slb_pkg::MODE_W-1:0] storage_control_mode,
	// storage controller side
	output logic storage_request,
	input wire logic storage_grant,
	output logic storage_write,
	output logic [slb_pkg::SEL_W-1:0] byte_select,
	output logic [slb_pkg::CODE_W-1:0] requester_code,
	input wire logic [slb_pkg::ADDR_W-1:0] shared_address_bus_i,
	output logic [slb_pkg::ADDR_W-1:0] shared_address_bus_o,
	output logic shared_address_bus_oe,
	input wire logic [slb_pkg::BUS_W-1:0] storage_data_i,
	output logic [slb_pkg::BUS_W-1:0] storage_data_o,
	output logic storage_data_oe,
	input wire logic data_valid,
	input wire logic line_invalidate
);

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int IDX_W = $clog2(ROWS);
	localparam int TAG_W = slb_pkg::ADDR_W - slb_pkg::OFS_W - IDX_W;
	localparam int MEM_WORDS = slb_pkg::SETS * ROWS * slb_pkg::LINE_WORDS;
	localparam int MA_W = $clog2(MEM_WORDS);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_LOOK,
		ST_INVAL,
		ST_FILL_REQ,
		ST_FILL_DATA,
		ST_RD_REQ,
		ST_RD_DATA,
		ST_WR_REQ
	} slb_state_t;

	slb_state_t state_reg;
	slb_state_t ret_reg;

	logic [slb_pkg::ADDR_W-1:0] req_addr_reg;
	logic req_we_reg;
	logic [slb_pkg::SEL_W-1:0] req_sel_reg;
	logic [slb_pkg::CODE_W-1:0] req_code_reg;
	logic [slb_pkg::DATA_W-1:0] req_wdata_reg;
	logic [slb_pkg::ADDR_W-1:0] inval_addr_reg;
	logic fill_set_reg;
	logic [slb_pkg::WORD_W-1:0] fill_cnt_reg;
	logic [slb_pkg::MODE_W-1:0] mode_reg;

	logic [slb_pkg::DATA_W-1:0] data_mem [MEM_WORDS];

	logic enabled;
	logic cacheable;
	logic inval_take;
	logic look_go;
	logic hit_use;
	logic fill_last;
	logic [slb_pkg::ADDR_W-1:0] dir_addr;
	logic [MA_W-1:0] hit_ma;
	logic [MA_W-1:0] fill_ma;

	slb_dir_if #(.IDX_W(IDX_W), .TAG_W(TAG_W)) dir_bus ();

	slb_directory #(.ROWS(ROWS), .IDX_W(IDX_W), .TAG_W(TAG_W)) u_dir (
		.mclk(mclk),
		.reset(reset),
		.d(dir_bus)
	);

	// word address within the data array: set, row, word of line
	function automatic logic [MA_W-1:0] mem_addr(input logic s,
			input logic [slb_pkg::ADDR_W-1:0] a, input logic [1:0] w);
		return {s, a[slb_pkg::OFS_W +: IDX_W], w};
	endfunction : mem_addr

	// ------------------------------------------------------------
	// mode lines, loaded by the core's storage-control output
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			mode_reg <= slb_pkg::MODE_RESET;
		end else if (mode_load) begin
			mode_reg <= mode_data;
		end
	end

	assign storage_control_mode = mode_reg;
	// buffer off: every read goes to storage, invalidations still apply
	assign enabled = mode_reg[slb_pkg::MODE_ENABLE_BIT];
	assign cacheable = (req_code_reg == slb_pkg::CODE_IFETCH) ||
		(req_code_reg == slb_pkg::CODE_PROG_READ);

	// ------------------------------------------------------------
	// decode of the current step
	// ------------------------------------------------------------
	// invalidation is only taken where no storage transfer is running
	assign inval_take = line_invalidate && (state_reg == ST_IDLE ||
		state_reg == ST_LOOK || state_reg == ST_FILL_REQ ||
		state_reg == ST_RD_REQ || state_reg == ST_WR_REQ);
	assign look_go = (state_reg == ST_LOOK) && !line_invalidate;
	assign hit_use = look_go && dir_bus.hit && enabled;
	assign fill_last = (state_reg == ST_FILL_DATA) && data_valid &&
		(fill_cnt_reg == slb_pkg::LAST_WORD);
	assign dir_addr = (state_reg == ST_INVAL) ? inval_addr_reg : req_addr_reg;
	assign hit_ma = mem_addr(dir_bus.hit_set, req_addr_reg,
		req_addr_reg[2 +: slb_pkg::WORD_W]);
	assign fill_ma = mem_addr(fill_set_reg, req_addr_reg, fill_cnt_reg);

	// ------------------------------------------------------------
	// directory requests
	// ------------------------------------------------------------
	assign dir_bus.idx = dir_addr[slb_pkg::OFS_W +: IDX_W];
	assign dir_bus.tag = dir_addr[slb_pkg::ADDR_W-1 -: TAG_W];
	assign dir_bus.touch = hit_use;
	assign dir_bus.fill = fill_last;
	assign dir_bus.inval = (state_reg == ST_INVAL);
	assign dir_bus.set = fill_last ? fill_set_reg : dir_bus.hit_set;

	// ------------------------------------------------------------
	// core request capture
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			req_addr_reg <= '0;
			req_we_reg <= 1'b0;
			req_sel_reg <= '0;
			req_code_reg <= '0;
			req_wdata_reg <= '0;
		end else if (state_reg == ST_IDLE && !line_invalidate && core_req && !core_ack) begin
			req_addr_reg <= core_addr;
			req_we_reg <= core_we;
			req_sel_reg <= slb_pkg::slb_byte_sel(core_size, core_addr[1:0]);
			req_code_reg <= core_code;
			req_wdata_reg <= core_wdata;
		end
	end

	// ------------------------------------------------------------
	// sequencer and storage request outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			ret_reg <= ST_IDLE;
			inval_addr_reg <= '0;
			fill_set_reg <= 1'b0;
			storage_request <= 1'b0;
			storage_write <= 1'b0;
			byte_select <= '0;
			requester_code <= '0;
			shared_address_bus_o <= '0;
			shared_address_bus_oe <= 1'b0;
			storage_data_o <= '0;
			storage_data_oe <= 1'b0;
		end else if (inval_take) begin
			// release the bus and take the controller's address
			inval_addr_reg <= shared_address_bus_i;
			shared_address_bus_oe <= 1'b0;
			storage_request <= 1'b0;
			storage_data_oe <= 1'b0;
			ret_reg <= state_reg;
			state_reg <= ST_INVAL;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (core_req && !core_ack) begin
						state_reg <= ST_LOOK;
					end
				end
				ST_LOOK: begin
					requester_code <= req_code_reg;
					shared_address_bus_oe <= 1'b1;
					storage_request <= 1'b1;
					if (req_we_reg) begin
						// store-through: storage is written hit or miss
						storage_write <= 1'b1;
						byte_select <= req_sel_reg;
						shared_address_bus_o <= req_addr_reg;
						storage_data_o <= slb_pkg::slb_with_par(req_wdata_reg);
						storage_data_oe <= 1'b1;
						state_reg <= ST_WR_REQ;
					end else if (dir_bus.hit && enabled) begin
						shared_address_bus_oe <= 1'b0;
						storage_request <= 1'b0;
						state_reg <= ST_IDLE;
					end else if (cacheable && enabled) begin
						storage_write <= 1'b0;
						byte_select <= slb_pkg::SEL_ALL;
						shared_address_bus_o <= {req_addr_reg[slb_pkg::ADDR_W-1:slb_pkg::OFS_W],
							{slb_pkg::OFS_W{1'b0}}};
						fill_set_reg <= dir_bus.victim;
						state_reg <= ST_FILL_REQ;
					end else begin
						storage_write <= 1'b0;
						byte_select <= req_sel_reg;
						shared_address_bus_o <= req_addr_reg;
						state_reg <= ST_RD_REQ;
					end
				end
				ST_INVAL: begin
					// the line is dropped this cycle; resume what was pending
					state_reg <= ret_reg;
					storage_request <= (ret_reg == ST_FILL_REQ) ||
						(ret_reg == ST_RD_REQ) || (ret_reg == ST_WR_REQ);
					shared_address_bus_oe <= (ret_reg == ST_FILL_REQ) ||
						(ret_reg == ST_RD_REQ) || (ret_reg == ST_WR_REQ);
					storage_data_oe <= (ret_reg == ST_WR_REQ);
				end
				ST_FILL_REQ, ST_RD_REQ, ST_WR_REQ: begin
					if (storage_grant) begin
						storage_request <= 1'b0;
						shared_address_bus_oe <= 1'b0;
						storage_data_oe <= 1'b0;
						storage_write <= 1'b0;
						case (state_reg)
							ST_FILL_REQ: state_reg <= ST_FILL_DATA;
							ST_RD_REQ: state_reg <= ST_RD_DATA;
							default: state_reg <= ST_IDLE;
						endcase
					end
				end
				ST_FILL_DATA: begin
					if (fill_last) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_RD_DATA: begin
					if (data_valid) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// line fill word counter; words arrive in line order
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			fill_cnt_reg <= '0;
		end else if (state_reg != ST_FILL_DATA) begin
			fill_cnt_reg <= '0;
		end else if (data_valid) begin
			fill_cnt_reg <= fill_cnt_reg + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// data array: line loads and write hits
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (state_reg == ST_FILL_DATA && data_valid) begin
			data_mem[fill_ma] <= storage_data_i[slb_pkg::DATA_W-1:0];
		end else if (hit_use && req_we_reg) begin
			for (int b = 0; b < slb_pkg::SEL_W; b++) begin
				if (req_sel_reg[b]) begin
					data_mem[hit_ma][31 - 8 * b -: 8] <= req_wdata_reg[31 - 8 * b -: 8];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// answers to the core
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			core_ack <= 1'b0;
			core_rdata <= '0;
			buffer_miss <= 1'b0;
		end else begin
			core_ack <= 1'b0;
			buffer_miss <= 1'b0;
			case (state_reg)
				ST_LOOK: begin
					if (hit_use && !req_we_reg) begin
						core_ack <= 1'b1;
						core_rdata <= data_mem[hit_ma];
					end
					buffer_miss <= look_go && !req_we_reg && !hit_use;
				end
				ST_WR_REQ: begin
					// write released on grant, storage update runs on
					core_ack <= storage_grant && !line_invalidate;
				end
				ST_FILL_DATA: begin
					if (data_valid && fill_cnt_reg == req_addr_reg[2 +: slb_pkg::WORD_W]) begin
						core_rdata <= storage_data_i[slb_pkg::DATA_W-1:0];
					end
					core_ack <= fill_last;
				end
				ST_RD_DATA: begin
					if (data_valid) begin
						core_ack <= 1'b1;
						core_rdata <= storage_data_i[slb_pkg::DATA_W-1:0];
					end
				end
				default: begin
					core_ack <= 1'b0;
				end
			endcase
		end
	end

endmodule : slb_line_buffer

// file: verification/slb_line_buffer_properties.sv
/* checker of the line buffer's core and storage ports, bound to every slb_line_buffer.
 * assumes: one clock mclk, synchronous active-high reset. */
`timescale 1ns/1ns
module slb_line_buffer_checker #(
	parameter int ROWS = 512
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic core_ack,
	input wire logic buffer_miss,
	input wire logic mode_load,
	input wire logic [7:0] mode_data,
	input wire logic [7:0] storage_control_mode,
	input wire logic storage_request,
	input wire logic storage_grant,
	input wire logic storage_write,
	input wire logic [3:0] byte_select,
	input wire logic line_invalidate,
	input wire logic [24:0] shared_address_bus_o,
	input wire logic shared_address_bus_oe,
	input wire logic [35:0] storage_data_o,
	input wire logic storage_data_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_mode_reset: assert property (disable iff (1'b0) reset |=> storage_control_mode == 8'h01)
		else $error("mode lines not at reset value");
	a_mode_load: assert property (mode_load |=> storage_control_mode == $past(mode_data))
		else $error("mode lines did not take the loaded value");
	a_miss_to_store: assert property (buffer_miss |-> ##[0:4] storage_request)
		else $error("read miss without storage request");
	a_req_hold: assert property (storage_request && !storage_grant && !line_invalidate
		|=> storage_request && $stable(shared_address_bus_o)) else $error("request dropped before grant");
	a_grant_drop: assert property (storage_request && storage_grant |=> !storage_request)
		else $error("request still high after grant");
	a_oe_with_req: assert property (storage_request |-> shared_address_bus_oe || $past(line_invalidate))
		else $error("request without address drive");
	a_inval_release: assert property (line_invalidate && shared_address_bus_oe |=> !shared_address_bus_oe)
		else $error("address bus still driven during invalidate");
	a_write_release: assert property (storage_request && storage_grant && storage_write && !line_invalidate
		|-> ##[1:2] core_ack) else $error("core not released after write grant");
	a_write_lanes: assert property (storage_request && storage_write |-> storage_data_oe
		&& byte_select inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf}) else $error("bad write lanes");
	a_odd_parity: assert property (storage_data_oe |-> storage_data_o[35:32] == {~^storage_data_o[7:0],
		~^storage_data_o[15:8], ~^storage_data_o[23:16], ~^storage_data_o[31:24]}) else $error("bad parity");

	c_fill: cover property (storage_grant && storage_request && !storage_write);
	c_write: cover property (storage_grant && storage_request && storage_write);
	c_inval: cover property (line_invalidate && shared_address_bus_oe);
	c_miss: cover property (buffer_miss);
endmodule : slb_line_buffer_checker

bind slb_line_buffer slb_line_buffer_checker #(.ROWS(ROWS)) u_slb_line_buffer_checker (.*);

// file: verification/slb_storage_model.sv
/* storage controller model: grants requests, returns line fills and word reads, raises invalidations.
 * assumes: sees the line buffer's storage-side outputs on mclk; the bench resolves the shared wires. */
`timescale 1ns/1ns
module slb_storage_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic slow,
	input wire logic storage_request,
	input wire logic storage_write,
	input wire logic [3:0] byte_select,
	input wire logic [2:0] requester_code,
	input wire logic [24:0] shared_address_bus_o,
	input wire logic [35:0] storage_data_o,
	output logic storage_grant,
	output logic data_valid,
	output logic line_invalidate,
	output logic [24:0] sad_p,
	output logic sad_pe,
	output logic [35:0] sd_w
);
	logic [31:0] mem [int];
	logic [31:0] dw, v;
	logic drv, quiet;
	int grants, words, st, dly, k, n, wa;
	wire logic [35:0] sd_full = {~^dw[7:0], ~^dw[15:8], ~^dw[23:16], ~^dw[31:24], dw};

	// released data lines show the inverse of the last word, never a stale copy
	assign sd_w = drv ? sd_full : ~sd_full;

	function automatic logic [31:0] rd(int w);
		return mem.exists(w) ? mem[w] : 32'(w) * 32'h9e37_79b1;
	endfunction : rd

	initial begin
		{storage_grant, data_valid, line_invalidate, sad_pe, drv, quiet} = 6'h00;
		sad_p = 25'h0000000;
		dw = 32'h00000000;
	end

	always @(posedge mclk) begin
		storage_grant <= 1'b0;
		data_valid <= 1'b0;
		drv <= 1'b0;
		if (reset)
			st = 0;
		else case (st)
			0: if (storage_request && !line_invalidate && !quiet) begin
				dly = slow ? 8 : $urandom_range(0, 3);
				st = 1;
			end
			1: if (!storage_request || line_invalidate)
				st = 0;
			else if (dly > 0)
				dly--;
			else begin
				storage_grant <= 1'b1;
				grants++;
				wa = int'(shared_address_bus_o[24:2]);
				k = 0;
				n = (requester_code <= 3'h1 && shared_address_bus_o[3:0] == 4'h0) ? 4 : 1;
				st = storage_write ? 3 : 2;
				v = rd(wa);
				for (int b = 0; b < 4; b++)
					if (byte_select[b]) v[31 - 8 * b -: 8] = storage_data_o[31 - 8 * b -: 8];
				if (storage_write) mem[wa] = v;
			end
			2: if ($urandom_range(0, 1)) begin
				dw <= rd(wa + k);
				drv <= 1'b1;
				data_valid <= 1'b1;
				k++;
				words++;
				if (k == n) st = 3;
			end
			default: if (!storage_request) st = 0;
		endcase
	end

	task automatic invalidate(input logic [24:0] a);
		@(posedge mclk);
		line_invalidate <= 1'b1;
		sad_p <= a;
		sad_pe <= 1'b1;
		quiet <= 1'b1;
		@(posedge mclk);
		line_invalidate <= 1'b0;
		sad_pe <= 1'b0;
		@(posedge mclk);
		quiet <= 1'b0;
	endtask : invalidate
endmodule : slb_storage_model

// file: verification/tb_top.sv
/* self-checking bench of slb_line_buffer against a reference of valid lines and storage words.
 * assumes: slb_storage_model on the storage side; core inputs change at the falling edge. */
`timescale 1ns/1ns
module tb_top;
	logic mclk, reset, core_req, core_we, core_ack, buffer_miss, mode_load, storage_request, storage_grant;
	logic storage_write, shared_address_bus_oe, storage_data_oe, data_valid, line_invalidate, sad_pe, slow;
	slb_pkg::slb_size_t core_size;
	logic [24:0] core_addr, shared_address_bus_i, shared_address_bus_o, sad_p;
	logic [31:0] core_wdata, core_rdata;
	logic [35:0] storage_data_i, storage_data_o, sd_w;
	logic [7:0] mode_data, storage_control_mode;
	logic [3:0] byte_select;
	logic [2:0] core_code, requester_code;
	logic [31:0] rm [int];
	bit vl [int];
	bit en = 1'b1;
	int fail_count, n_tests, cyc;

	// the controller's address wins while it invalidates; an undriven bus shows the inverse
	assign shared_address_bus_i = sad_pe ? sad_p : shared_address_bus_oe ? shared_address_bus_o : ~shared_address_bus_o;
	assign storage_data_i = storage_data_oe ? storage_data_o : sd_w;

	slb_line_buffer #(.ROWS(512)) u_slb_line_buffer (.*);
	slb_storage_model u_slb_storage_model (.*);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	function automatic logic [31:0] rw(int w);
		return rm.exists(w) ? rm[w] : 32'(w) * 32'h9e37_79b1;
	endfunction : rw

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_data

	task automatic chk_cnt(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			fail_count++;
			$display("Error at %0t: count %h expected %h", $time, got, exp);
		end
	endtask : chk_cnt

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// one core access, checked against the reference
	// ------------------------------------------------------------
	task automatic op(input logic we, input slb_pkg::slb_size_t sz, input logic [24:0] a, input logic [2:0] cd,
		input logic [31:0] wd);
		int g, w, ln, wa, eg, ew;
		logic m, mx;
		logic [3:0] sel;
		logic [31:0] v;
		ln = int'(a[24:4]);
		wa = int'(a[24:2]);
		g = u_slb_storage_model.grants;
		w = u_slb_storage_model.words;
		m = 1'b0;
		mx = !we && !(en && vl.exists(ln));
		@(negedge mclk);
		core_we = we;
		core_addr = a;
		core_code = cd;
		core_wdata = wd;
		core_req = 1'b1;
		core_size = sz;
		do begin
			@(negedge mclk);
			m |= buffer_miss;
		end while (core_ack !== 1'b1);
		core_req = 1'b0;
		eg = 1;
		ew = 0;
		if (we) begin
			sel = sz == slb_pkg::SLB_SZ_BYTE ? 4'h1 << a[1:0] : sz == slb_pkg::SLB_SZ_HALF ? (a[1] ? 4'hc : 4'h3) : 4'hf;
			v = rw(wa);
			for (int b = 0; b < 4; b++)
				if (sel[b]) v[31 - 8 * b -: 8] = wd[31 - 8 * b -: 8];
			rm[wa] = v;
			chk_data(u_slb_storage_model.mem[wa], v);
		end else if (!mx)
			eg = 0;
		else if (en && cd <= 3'h1) begin
			ew = 4;
			vl[ln] = 1'b1;
		end else
			ew = 1;
		if (!we) chk_data(core_rdata, rw(wa));
		chk_data({31'h0, m}, {31'h0, mx});
		chk_cnt(u_slb_storage_model.grants - g, eg);
		chk_cnt(u_slb_storage_model.words - w, ew);
	endtask : op

	task automatic setmode(input logic [7:0] d);
		@(negedge mclk);
		mode_data = d;
		mode_load = 1'b1;
		@(negedge mclk);
		mode_load = 1'b0;
		en = d[0];
		chk_data({24'h0, storage_control_mode}, {24'h0, d});
	endtask : setmode

	initial begin
		logic [24:0] a;
		logic we;
		slb_pkg::slb_size_t sz;
		{reset, core_req, core_we, mode_load, slow} = 5'h10;
		{core_addr, core_code, core_wdata, mode_data} = '0;
		core_size = slb_pkg::SLB_SZ_WORD;
		void'($urandom(32'h1faa));
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		chk_data({24'h0, storage_control_mode}, 32'h01);
		chk_data({31'h0, storage_request}, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 48; i++) begin
			a = 25'($urandom_range(0, 1)) << 13 | 25'($urandom_range(0, 7)) << 4 | 25'($urandom_range(0, 15));
			we = $urandom_range(0, 2) == 0;
			sz = we ? slb_pkg::slb_size_t'($urandom_range(0, 2)) : slb_pkg::SLB_SZ_WORD;
			if (sz != slb_pkg::SLB_SZ_BYTE) a[0] = 1'b0;
			if (sz == slb_pkg::SLB_SZ_WORD) a[1] = 1'b0;
			slow = 1'($urandom_range(0, 1));
			op(we, sz, a, 3'($urandom_range(0, 5)), $urandom);
		end
		slow = 1'b0;
		$display("random access test done");
		// three cacheable lines on one row: the least recently used set must be the one replaced
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h0a0, 3'h0, 32'h0);
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h20a0, 3'h1, 32'h0);
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h0a4, 3'h0, 32'h0);
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h40a8, 3'h0, 32'h0);
		vl.delete('h20a);
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h0ac, 3'h1, 32'h0);
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h20a4, 3'h0, 32'h0);
		vl.delete('h40a);
		$display("replacement test done");
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h40, 3'h0, 32'h0);
		u_slb_storage_model.invalidate(25'h40);
		vl.delete(4);
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h44, 3'h1, 32'h0);
		vl.delete(4);
		fork
			u_slb_storage_model.invalidate(25'h48);
			begin
				@(posedge mclk);
				op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h48, 3'h0, 32'h0);
			end
		join
		slow = 1'b1;
		fork
			op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h2090, 3'h2, 32'h0);
			begin
				repeat (5) @(posedge mclk);
				u_slb_storage_model.invalidate(25'h40);
			end
		join
		slow = 1'b0;
		vl.delete(4);
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h4c, 3'h0, 32'h0);
		$display("invalidation test done");
		setmode(8'h00);
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h44, 3'h0, 32'h0);
		setmode(8'h01);
		op(1'b0, slb_pkg::SLB_SZ_WORD, 25'h44, 3'h0, 32'h0);
		$display("mode test done");
		report_and_stop();
	end
endmodule : tb_top
